// ==== rtl/ocd_device.sv ====
// Programmable oscillator divider with single-wire configuration port
`timescale 1ns/1ps
// Function
// - Mode word pattern 00011,ratio,bypasses,0
// - Divider bypass routes master clock out; the code toggles the output every pclk cycle instead, giving pclk/2
// - Divider bypass also skips the prescaler
// - Prescaler bypass bit skips prescaler
// - Ratio 0 divides four, 1 two
// - Divisor equals stored code plus two
// - New words apply only after power cycle
// - Written words saved automatically
// - Stabilize 1024 cycles at max, then load
// - Pin high at power-up: programming
// - Pin low: normal, pin drives clock
// - Reset, presence, command, data
// - Eight command bits, LSB first
// - 01H writes, A1H reads divisor
// - 02H writes, A2H reads mode
// - Nine data bits, LSB first
// - Master falling edge starts every slot
// - Read zero holds line low
module ocd_device (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Shared pin
  ocd_if.dev pin,
  // User side
  input wire logic factory_load,
  output logic prog_mode,
  output logic [8:0] nv_div,
  output logic [8:0] nv_mode
);
  ocd_pkg::ocd_dev_e state, next_state;
  logic s1, s2, s3;
  logic [11:0] tcnt, next_tcnt, lowcnt, next_lowcnt, scnt, next_scnt;
  logic [11:0] ocnt, next_ocnt, dsel, n2;
  logic in_slot, next_in_slot, op_rd, next_op_rd, op_div, next_op_div;
  logic [3:0] bitcnt, next_bitcnt;
  logic [8:0] sh, next_sh, act_div, next_act_div, act_mode, next_act_mode;
  logic [8:0] next_nv_div, next_nv_mode;
  logic clk_q, next_clk_q, next_dev_out, next_dev_oe, next_prog_mode;
  logic fall, rise, rd_slot;

  // ----------------------------------------
  // Output divisor
  // ----------------------------------------
  always_comb
  begin
    n2 = {3'h0, act_div} + ocd_pkg::DIV_OFFSET;
    if (act_mode[ocd_pkg::MODE_DBP_BIT])
      dsel = 12'h001;
    else if (act_mode[ocd_pkg::MODE_PSB_BIT])
      dsel = n2;
    else if (act_mode[ocd_pkg::MODE_RATIO_BIT])
      dsel = {n2[10:0], 1'b0};
    else
      dsel = {n2[9:0], 2'b00};
  end
  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    fall = s3 & ~s2;
    rise = ~s3 & s2;
    rd_slot = (state == ocd_pkg::ST_DATA) & op_rd;
    next_state = state;
    next_tcnt = tcnt;
    next_scnt = scnt;
    next_in_slot = in_slot;
    next_op_rd = op_rd;
    next_op_div = op_div;
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_act_div = act_div;
    next_act_mode = act_mode;
    next_nv_div = nv_div;
    next_nv_mode = nv_mode;
    next_clk_q = clk_q;
    next_ocnt = 12'h000;
    next_dev_out = 1'b0;
    next_dev_oe = pin.dev_oe;
    next_prog_mode = prog_mode;
    next_lowcnt = s2 ? 12'h000 : (lowcnt == ocd_pkg::RDET_CYC ? lowcnt : lowcnt + 12'h001);
    if (factory_load)
    begin
      next_nv_div = ocd_pkg::DIV_DFLT;
      next_nv_mode = ocd_pkg::MODE_DFLT;
    end
    unique case (state)
      ocd_pkg::ST_POR:
      begin
        // hold at max, then load stored words
        next_act_div = ocd_pkg::DIV_MAX;
        next_act_mode = ocd_pkg::MODE_MAX;
        next_tcnt = tcnt + 12'h001;
        if (tcnt == ocd_pkg::STAB_CYC - 12'h001)
        begin
          next_tcnt = 12'h000;
          if (s2)
          begin
            next_state = ocd_pkg::ST_IDLE;
            next_prog_mode = 1'b1;
          end
          else
          begin
            next_state = ocd_pkg::ST_RUN;
            next_act_div = nv_div;
            next_act_mode = nv_mode;
            next_dev_oe = 1'b1;
          end
        end
      end
      ocd_pkg::ST_RUN:
      begin
        next_ocnt = ocnt + 12'h001;
        if (ocnt >= dsel - 12'h001)
        begin
          next_ocnt = 12'h000;
          next_clk_q = ~clk_q;
        end
        next_dev_out = next_clk_q;
      end
      ocd_pkg::ST_IDLE:
      begin
      end
      ocd_pkg::ST_PWAIT:
      begin
        next_tcnt = tcnt + 12'h001;
        if (tcnt == ocd_pkg::PWAIT_CYC - 12'h001)
        begin
          next_state = ocd_pkg::ST_PRES;
          next_tcnt = 12'h000;
          next_dev_oe = 1'b1;
        end
      end
      ocd_pkg::ST_PRES:
      begin
        next_tcnt = tcnt + 12'h001;
        if (tcnt == ocd_pkg::PRES_CYC - 12'h001)
        begin
          next_state = ocd_pkg::ST_CMD;
          next_dev_oe = 1'b0;
          next_bitcnt = 4'h0;
          next_in_slot = 1'b0;
        end
      end
      ocd_pkg::ST_CMD, ocd_pkg::ST_DATA:
      begin
        if (!in_slot && state == ocd_pkg::ST_CMD && bitcnt == ocd_pkg::CMD_BITS)
        begin
          next_state = ocd_pkg::ST_DATA;
          next_bitcnt = 4'h0;
          unique case (sh[8:1])
            ocd_pkg::CMD_WR_DIV: {next_op_rd, next_op_div} = 2'b01;
            ocd_pkg::CMD_RD_DIV: {next_op_rd, next_op_div, next_sh} = {2'b11, nv_div};
            ocd_pkg::CMD_WR_MODE: {next_op_rd, next_op_div} = 2'b00;
            ocd_pkg::CMD_RD_MODE: {next_op_rd, next_op_div, next_sh} = {2'b10, nv_mode};
            default: next_state = ocd_pkg::ST_IDLE;
          endcase
        end
        else if (!in_slot && state == ocd_pkg::ST_DATA && bitcnt == ocd_pkg::DATA_BITS)
        begin
          next_state = ocd_pkg::ST_IDLE;
          if (!op_rd && op_div)
            next_nv_div = sh;
          else if (!op_rd)
            next_nv_mode = sh;
        end
        else if (!in_slot && fall)
        begin
          next_in_slot = 1'b1;
          next_scnt = 12'h000;
          // pull low only for a zero
          next_dev_oe = rd_slot & ~sh[0];
        end
        else if (in_slot)
        begin
          next_scnt = scnt + 12'h001;
          if (scnt == ocd_pkg::SAMP_CYC - 12'h001 && !rd_slot)
          begin
            next_sh = {s2, sh[8:1]};
            next_bitcnt = bitcnt + 4'h1;
          end
          if (scnt == ocd_pkg::HOLD_CYC - 12'h001)
          begin
            next_in_slot = 1'b0;
            next_dev_oe = 1'b0;
            if (rd_slot)
            begin
              next_sh = {1'b0, sh[8:1]};
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
      end
      default: next_state = ocd_pkg::ST_POR;
    endcase
    // long low pulse restarts a transaction
    if (prog_mode && rise && lowcnt == ocd_pkg::RDET_CYC)
    begin
      next_state = ocd_pkg::ST_PWAIT;
      next_tcnt = 12'h000;
      next_in_slot = 1'b0;
      next_dev_oe = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ocd_pkg::ST_POR;
      {s1, s2, s3} <= 3'h0;
      tcnt <= 12'h000;
      lowcnt <= 12'h000;
      scnt <= 12'h000;
      ocnt <= 12'h000;
      in_slot <= 1'b0;
      op_rd <= 1'b0;
      op_div <= 1'b0;
      bitcnt <= 4'h0;
      sh <= 9'h000;
      act_div <= ocd_pkg::DIV_MAX;
      act_mode <= ocd_pkg::MODE_MAX;
      clk_q <= 1'b0;
      pin.dev_out <= 1'b0;
      pin.dev_oe <= 1'b0;
      prog_mode <= 1'b0;
    end
    else
    begin
      state <= next_state;
      s1 <= pin.line;
      s2 <= s1;
      s3 <= s2;
      tcnt <= next_tcnt;
      lowcnt <= next_lowcnt;
      scnt <= next_scnt;
      ocnt <= next_ocnt;
      in_slot <= next_in_slot;
      op_rd <= next_op_rd;
      op_div <= next_op_div;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      act_div <= next_act_div;
      act_mode <= next_act_mode;
      clk_q <= next_clk_q;
      pin.dev_out <= next_dev_out;
      pin.dev_oe <= next_dev_oe;
      prog_mode <= next_prog_mode;
    end
  end

  // Nonvolatile store survives reset
  always_ff @(posedge pclk)
  begin
    nv_div <= next_nv_div;
    nv_mode <= next_nv_mode;
  end
endmodule : ocd_device

// ==== rtl/ocd_pkg.sv ====
// Shared constants and types for the oscillator divider and its programmer
package ocd_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_NS = 40;
  localparam int T_RDET_NS = 40000;
  localparam int T_PWAIT_NS = 5000;
  localparam int T_PRES_NS = 20000;
  localparam int T_SAMP_NS = 10000;
  localparam int T_HOLD_NS = 15000;
  localparam int T_MRST_NS = 48000;
  localparam int T_MPSMP_NS = 12000;
  localparam int T_MRECOV_NS = 40000;
  localparam int T_W0_NS = 20000;
  localparam int T_W1_NS = 2000;
  localparam int T_RDLOW_NS = 1000;
  localparam int T_MSAMP_NS = 5000;
  localparam int T_SLOT_NS = 30000;
  localparam logic [11:0] STAB_CYC = 12'h400;
  localparam logic [11:0] RDET_CYC = 12'((T_RDET_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] PWAIT_CYC = 12'((T_PWAIT_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] PRES_CYC = 12'((T_PRES_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] SAMP_CYC = 12'((T_SAMP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] HOLD_CYC = 12'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] MRST_CYC = 12'((T_MRST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] MPSMP_CYC = 12'((T_MPSMP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] MRECOV_CYC = 12'((T_MRECOV_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] W0_CYC = 12'((T_W0_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] W1_CYC = 12'((T_W1_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] RDLOW_CYC = 12'((T_RDLOW_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] MSAMP_CYC = 12'((T_MSAMP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [11:0] SLOT_CYC = 12'((T_SLOT_NS + CLK_NS - 1) / CLK_NS);
  // ----------------------------------------
  // Configuration words
  // ----------------------------------------
  localparam int MODE_RATIO_BIT = 3;
  localparam int MODE_PSB_BIT = 2;
  localparam int MODE_DBP_BIT = 1;
  localparam logic [8:0] DIV_DFLT = 9'h000;
  localparam logic [8:0] MODE_DFLT = 9'h034;
  localparam logic [8:0] DIV_MAX = 9'h1ff;
  localparam logic [8:0] MODE_MAX = 9'h030;
  localparam logic [11:0] DIV_OFFSET = 12'h002;
  localparam logic [3:0] CMD_BITS = 4'h8;
  localparam logic [3:0] DATA_BITS = 4'h9;
  localparam logic [7:0] CMD_WR_DIV = 8'h01;
  localparam logic [7:0] CMD_RD_DIV = 8'ha1;
  localparam logic [7:0] CMD_WR_MODE = 8'h02;
  localparam logic [7:0] CMD_RD_MODE = 8'ha2;
  localparam int CMD_RD_BIT = 7;
  // ----------------------------------------
  // Programmer registers
  // ----------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_CMD = 8'h04;
  localparam logic [7:0] REG_WDATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [4:0] XFER_LAST = 5'h10;
  // ----------------------------------------
  // States
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_POR = 3'b000, ST_IDLE = 3'b001, ST_PWAIT = 3'b011, ST_PRES = 3'b010,
    ST_CMD = 3'b110, ST_DATA = 3'b111, ST_RUN = 3'b100
  } ocd_dev_e;
  typedef enum logic [1:0] {
    HS_IDLE = 2'b00, HS_RST = 2'b01, HS_REL = 2'b11, HS_SLOT = 2'b10
  } ocd_mst_e;
endpackage : ocd_pkg

// ==== rtl/ocd_if.sv ====
// Shared pin between the oscillator divider and its programmer
`timescale 1ns/1ps
interface ocd_if;
  logic dev_out;
  logic dev_oe;
  logic mst_oe;
  logic pull_en;
  logic line;
  // Device push-pull, master pulls low only, pullup else weak low
  assign line = (dev_oe ? dev_out : pull_en) & ~mst_oe;
  modport dev (input line, output dev_out, output dev_oe);
  modport mst (input line, output mst_oe, output pull_en);
endinterface : ocd_if

// ==== rtl/ocd_master.sv ====
// Single-wire programmer for the oscillator divider, APB controlled
`timescale 1ns/1ps
module ocd_master (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared pin
  ocd_if.mst pin
);
  ocd_pkg::ocd_mst_e state, next_state;
  logic s1, s2;
  logic [11:0] tcnt, next_tcnt, lowlen;
  logic [4:0] bitcnt, next_bitcnt;
  logic [16:0] sh, next_sh;
  logic [7:0] cmd, next_cmd;
  logic [8:0] wdata, next_wdata, rdata, next_rdata;
  logic rd, next_rd, busy, next_busy, present, next_present;
  logic next_pull_en, next_mst_oe, next_pready, next_pslverr, rd_bit, wr_ok;
  logic [31:0] next_prdata;

  // ----------------------------------------
  // Bus and transfer engine
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    next_tcnt = tcnt;
    next_bitcnt = bitcnt;
    next_sh = sh;
    next_cmd = cmd;
    next_wdata = wdata;
    next_rdata = rdata;
    next_rd = rd;
    next_busy = busy;
    next_present = present;
    next_pull_en = pin.pull_en;
    next_mst_oe = pin.mst_oe;
    next_prdata = prdata;
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    wr_ok = psel & penable & pready & pwrite;
    rd_bit = rd & (bitcnt >= 5'h08);
    lowlen = rd_bit ? ocd_pkg::RDLOW_CYC : (sh[0] ? ocd_pkg::W1_CYC : ocd_pkg::W0_CYC);
    if (psel && penable && !pready)
    begin
      next_pready = 1'b1;
      unique case (paddr)
        ocd_pkg::REG_CTRL: next_prdata = {31'h0, pin.pull_en};
        ocd_pkg::REG_CMD: next_prdata = {24'h0, cmd};
        ocd_pkg::REG_WDATA: next_prdata = {23'h0, wdata};
        ocd_pkg::REG_STAT: next_prdata = {30'h0, present, busy};
        ocd_pkg::REG_RDATA: next_prdata = {23'h0, rdata};
        default:
        begin
          next_prdata = 32'h0;
          next_pslverr = 1'b1;
        end
      endcase
    end
    if (wr_ok && paddr == ocd_pkg::REG_CTRL)
      next_pull_en = pwdata[0];
    if (wr_ok && paddr == ocd_pkg::REG_WDATA)
      next_wdata = pwdata[8:0];
    unique case (state)
      ocd_pkg::HS_IDLE:
      begin
        if (wr_ok && paddr == ocd_pkg::REG_CMD)
        begin
          next_cmd = pwdata[7:0];
          next_sh = {wdata, pwdata[7:0]};
          next_rd = pwdata[ocd_pkg::CMD_RD_BIT];
          next_busy = 1'b1;
          next_present = 1'b0;
          next_tcnt = 12'h000;
          next_mst_oe = 1'b1;
          next_state = ocd_pkg::HS_RST;
        end
      end
      ocd_pkg::HS_RST:
      begin
        next_tcnt = tcnt + 12'h001;
        if (tcnt == ocd_pkg::MRST_CYC - 12'h001)
        begin
          next_mst_oe = 1'b0;
          next_tcnt = 12'h000;
          next_state = ocd_pkg::HS_REL;
        end
      end
      ocd_pkg::HS_REL:
      begin
        next_tcnt = tcnt + 12'h001;
        if (tcnt == ocd_pkg::MPSMP_CYC - 12'h001)
          next_present = ~s2;
        if (tcnt == ocd_pkg::MRECOV_CYC - 12'h001)
        begin
          next_tcnt = 12'h000;
          next_bitcnt = 5'h00;
          next_state = present ? ocd_pkg::HS_SLOT : ocd_pkg::HS_IDLE;
          next_busy = present;
          next_mst_oe = present;
        end
      end
      ocd_pkg::HS_SLOT:
      begin
        next_tcnt = tcnt + 12'h001;
        // every slot opens with a low
        if (tcnt == lowlen - 12'h001)
          next_mst_oe = 1'b0;
        if (rd_bit && tcnt == ocd_pkg::MSAMP_CYC - 12'h001)
          next_rdata = {s2, rdata[8:1]};
        if (tcnt == ocd_pkg::SLOT_CYC - 12'h001)
        begin
          next_sh = {1'b0, sh[16:1]};
          next_bitcnt = bitcnt + 5'h01;
          next_tcnt = 12'h000;
          if (bitcnt == ocd_pkg::XFER_LAST)
          begin
            next_busy = 1'b0;
            next_state = ocd_pkg::HS_IDLE;
          end
          else
            next_mst_oe = 1'b1;
        end
      end
    endcase
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= ocd_pkg::HS_IDLE;
      {s1, s2} <= 2'h0;
      tcnt <= 12'h000;
      bitcnt <= 5'h00;
      sh <= 17'h0;
      cmd <= 8'h00;
      wdata <= 9'h000;
      rdata <= 9'h000;
      rd <= 1'b0;
      busy <= 1'b0;
      present <= 1'b0;
      pin.pull_en <= 1'b0;
      pin.mst_oe <= 1'b0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      state <= next_state;
      s1 <= pin.line;
      s2 <= s1;
      tcnt <= next_tcnt;
      bitcnt <= next_bitcnt;
      sh <= next_sh;
      cmd <= next_cmd;
      wdata <= next_wdata;
      rdata <= next_rdata;
      rd <= next_rd;
      busy <= next_busy;
      present <= next_present;
      pin.pull_en <= next_pull_en;
      pin.mst_oe <= next_mst_oe;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end
endmodule : ocd_master

// ==== testbench/ocd_props.sv ====
// Assertions on the shared pin between the divider and its programmer
`timescale 1ns/1ps
module ocd_props (
  // Clock and device reset
  input wire logic pclk,
  input wire logic presetn,
  // Pin signals
  input wire logic dev_out,
  input wire logic dev_oe,
  input wire logic mst_oe,
  input wire logic pull_en,
  input wire logic line,
  input wire logic prog_mode
);
  // ----------------------------------------
  // Helper counters
  // ----------------------------------------
  logic [11:0] cnt, next_cnt, lowc, next_lowc, tc, next_tc, li, next_li;
  logic [1:0] ntog, next_ntog;
  logic prev_out, next_prev_out, tog;
  assign tog = dev_out != prev_out;
  always_comb
  begin
    next_cnt = (cnt == 12'hfff) ? cnt : cnt + 12'h001;
    next_lowc = !mst_oe ? 12'h000 : (lowc == 12'hfff) ? lowc : lowc + 12'h001;
    next_tc = tog ? 12'h001 : (tc == 12'hfff) ? tc : tc + 12'h001;
    next_li = tog ? tc : li;
    next_ntog = (tog && ntog != 2'h3) ? ntog + 2'h1 : ntog;
    next_prev_out = dev_out;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 12'h000;
      lowc <= 12'h000;
      tc <= 12'h000;
      li <= 12'h000;
      ntog <= 2'h0;
      prev_out <= 1'b0;
    end
    else
    begin
      cnt <= next_cnt;
      lowc <= next_lowc;
      tc <= next_tc;
      li <= next_li;
      ntog <= next_ntog;
      prev_out <= next_prev_out;
    end
  end
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_stab_quiet: assert property (cnt < 12'h3e8 |-> !dev_oe && !prog_mode)
    else $error("pin driven during stabilization");
  a_strap_mode: assert property (cnt == 12'h406 |-> prog_mode == pull_en)
    else $error("mode does not follow the strap");
  a_run_drive: assert property (cnt >= 12'h406 && !prog_mode |-> dev_oe)
    else $error("pin not driven in normal operation");
  a_low_only: assert property (prog_mode && dev_oe |-> !dev_out)
    else $error("pin driven high while programming");
  a_presence_ans: assert property ($fell(mst_oe) && prog_mode && lowc >= 12'h3e8 |-> ##[100:200] (dev_oe && !dev_out && !line))
    else $error("no presence after reset pulse");
  a_zero_hold: assert property (prog_mode && $rose(dev_oe) |-> dev_oe [*8])
    else $error("low pulse too short");
  a_drive_ends: assert property (prog_mode && dev_oe |-> ##[1:600] !dev_oe)
    else $error("pin not released");
  // Longest master low is the 1200 cycle reset pulse
  a_mst_release: assert property (lowc <= 12'h4b0)
    else $error("master holds line low too long");
  a_run_steady: assert property (tog && dev_oe && !prog_mode && ntog >= 2'h2 |-> tc == li)
    else $error("output period changed while running");
endmodule : ocd_props

// ==== testbench/ocd_test.sv ====
// Self-checking bench joining the divider and its programmer
`timescale 1ns/1ps
module ocd_test;
  logic pclk, mst_rstn, dev_rstn, factory_load, psel, penable, pwrite, pready, pslverr, prog_mode, slv_err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [8:0] nv_div, nv_mode;
  int err_count, checks, seed, div_m, mode_m;
  ocd_if bus ();
  ocd_device ocd_device_i (.pclk(pclk), .presetn(dev_rstn), .pin(bus), .factory_load(factory_load),
    .prog_mode(prog_mode), .nv_div(nv_div), .nv_mode(nv_mode));
  ocd_master ocd_master_i (.pclk(pclk), .presetn(mst_rstn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin(bus));
  ocd_props ocd_props_i (.pclk(pclk), .presetn(dev_rstn), .dev_out(bus.dev_out), .dev_oe(bus.dev_oe),
    .mst_oe(bus.mst_oe), .pull_en(bus.pull_en), .line(bus.line), .prog_mode(prog_mode));
  initial
  begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_sim
  task chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_word
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdv = prdata;
    slv_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rd(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask : rd
  // One full reset, command and data transaction; store compared with model
  task xfer(input logic [7:0] cmd, input logic [8:0] wd);
    apb(1'b1, ocd_pkg::REG_WDATA, {23'h0, wd});
    apb(1'b1, ocd_pkg::REG_CMD, {24'h0, cmd});
    do rd(ocd_pkg::REG_STAT); while (rdv[0] !== 1'b0);
    chk_word({31'h0, rdv[1]}, 32'h1);
    repeat (20) @(posedge pclk);
    if (cmd[7])
    begin
      rd(ocd_pkg::REG_RDATA);
      chk_word(rdv, cmd[1] ? mode_m : div_m);
    end
    chk_word({23'h0, nv_div}, div_m);
    chk_word({23'h0, nv_mode}, mode_m);
  endtask : xfer
  // Power cycle of the device with the strap set or cleared
  task power(input logic prog);
    apb(1'b1, ocd_pkg::REG_CTRL, {31'h0, prog});
    rd(ocd_pkg::REG_CTRL);
    chk_word(rdv, {31'h0, prog});
    @(posedge pclk);
    dev_rstn <= 1'b0;
    @(posedge pclk);
    dev_rstn <= 1'b1;
    repeat (1040) @(posedge pclk);
    chk_word({31'h0, prog_mode}, {31'h0, prog});
  endtask : power
  task measure;
    int n, d;
    logic last;
    if (mode_m[1])
      d = 1;
    else if (mode_m[2])
      d = div_m + 2;
    else if (mode_m[3])
      d = 2 * (div_m + 2);
    else
      d = 4 * (div_m + 2);
    last = bus.line;
    do @(negedge pclk); while (bus.line === last);
    repeat (2)
    begin
      last = bus.line;
      n = 0;
      do
      begin
        @(negedge pclk);
        n++;
      end
      while (bus.line === last);
      chk_word(32'(n), 32'(d));
    end
  endtask : measure
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    seed = 71260;
    err_count = 0;
    checks = 0;
    mst_rstn = 1'b0;
    dev_rstn = 1'b0;
    factory_load = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (3) @(posedge pclk);
    mst_rstn <= 1'b1;
    dev_rstn <= 1'b1;
    @(posedge pclk);
    factory_load <= 1'b0;
    div_m = 0;
    mode_m = 'h34;
    rd(8'h14);
    chk_word(rdv, 32'h0);
    chk_word({31'h0, slv_err}, 32'h1);
    power(1'b0);
    measure();
    power(1'b1);
    div_m = $random(seed) & 7;
    xfer(ocd_pkg::CMD_WR_DIV, 9'(div_m));
    mode_m = 'h38;
    xfer(ocd_pkg::CMD_WR_MODE, 9'h038);
    xfer(ocd_pkg::CMD_RD_DIV, 9'($random(seed)));
    xfer(ocd_pkg::CMD_RD_MODE, 9'($random(seed)));
    power(1'b0);
    measure();
    power(1'b1);
    mode_m = 'h30;
    xfer(ocd_pkg::CMD_WR_MODE, 9'h030);
    power(1'b0);
    measure();
    power(1'b1);
    mode_m = 'h32;
    xfer(ocd_pkg::CMD_WR_MODE, 9'h032);
    power(1'b0);
    measure();
    end_sim();
  end
  // Six transactions of about 15000 cycles plus seven power-ups, small margin
  initial
  begin
    #4200000;
    err_count++;
    end_sim();
  end
endmodule : ocd_test
